/* File: inc/pdc_pkg.sv */
`default_nettype none

package pdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register port geometry
    localparam int PDC_ADDR_W = 10;          // serial port register address width
    localparam int PDC_DATA_W = 8;           // every register is one byte
    localparam int PDC_NUM_REGS = 6;         // registers held by this slice

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [9:0] PDC_OFS_PUMP_AND_LOOP_POWER_CONTROL = 10'h010;
    localparam logic [9:0] PDC_OFS_REFERENCE_DIVIDER_LOW       = 10'h011;
    localparam logic [9:0] PDC_OFS_REFERENCE_DIVIDER_HIGH      = 10'h012;
    localparam logic [9:0] PDC_OFS_SWALLOW_COUNTER_VALUE       = 10'h013;
    localparam logic [9:0] PDC_OFS_FEEDBACK_COUNT_LOW          = 10'h014;
    localparam logic [9:0] PDC_OFS_FEEDBACK_COUNT_HIGH         = 10'h015;

    ////////////////////////////////////////////////////////////////////////////////
    // register slot numbers inside the bank
    localparam int PDC_IDX_CTRL    = 0;
    localparam int PDC_IDX_REF_LO  = 1;
    localparam int PDC_IDX_REF_HI  = 2;
    localparam int PDC_IDX_SWALLOW = 3;
    localparam int PDC_IDX_FB_LO   = 4;
    localparam int PDC_IDX_FB_HI   = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values (control: pump normal 11, loop async power-down 01)
    localparam logic [7:0] PDC_RST_PUMP_AND_LOOP_POWER_CONTROL = 8'h0D;
    localparam logic [7:0] PDC_RST_REFERENCE_DIVIDER_LOW       = 8'h01;
    localparam logic [7:0] PDC_RST_REFERENCE_DIVIDER_HIGH      = 8'h00;
    localparam logic [7:0] PDC_RST_SWALLOW_COUNTER_VALUE       = 8'h00;
    localparam logic [7:0] PDC_RST_FEEDBACK_COUNT_LOW          = 8'h03;
    localparam logic [7:0] PDC_RST_FEEDBACK_COUNT_HIGH         = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // writable bit masks; cleared bits are unused and read zero
    localparam logic [7:0] PDC_MSK_PUMP_AND_LOOP_POWER_CONTROL = 8'h0F;
    localparam logic [7:0] PDC_MSK_REFERENCE_DIVIDER_LOW       = 8'hFF;
    localparam logic [7:0] PDC_MSK_REFERENCE_DIVIDER_HIGH      = 8'h3F;
    localparam logic [7:0] PDC_MSK_SWALLOW_COUNTER_VALUE       = 8'h3F;
    localparam logic [7:0] PDC_MSK_FEEDBACK_COUNT_LOW          = 8'hFF;
    localparam logic [7:0] PDC_MSK_FEEDBACK_COUNT_HIGH         = 8'h1F;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions in the control register, and field widths
    localparam int PDC_PUMP_LSB = 2;         // pump drive select [3:2]
    localparam int PDC_LOOP_LSB = 0;         // loop power select [1:0]
    localparam int PDC_REF_HI_W = 6;         // reference divider upper bits
    localparam int PDC_SWALLOW_W = 6;        // swallow counter width
    localparam int PDC_FB_HI_W = 5;          // feedback counter upper bits
    localparam int PDC_REF_W = 14;           // reference divider width
    localparam int PDC_FB_W = 13;            // feedback counter width

    ////////////////////////////////////////////////////////////////////////////////
    // field encodings
    typedef enum logic [1:0] {
        PDC_PUMP_TRISTATE = 2'h0,            // output high impedance
        PDC_PUMP_FORCE_UP = 2'h1,            // constant sourcing
        PDC_PUMP_FORCE_DN = 2'h2,            // constant sinking
        PDC_PUMP_NORMAL   = 2'h3             // detector driven
    } pdc_pump_t;

    typedef enum logic [1:0] {
        PDC_LOOP_NORMAL   = 2'h0,            // loop running
        PDC_LOOP_ASYNC_PD = 2'h1,            // asynchronous power-down
        PDC_LOOP_UNUSED   = 2'h2,            // reserved code
        PDC_LOOP_SYNC_PD  = 2'h3             // synchronous power-down
    } pdc_loop_t;

    // tables indexed by bank slot
    localparam logic [7:0] PDC_OFS_LOW_BYTE [PDC_NUM_REGS] = '{
        PDC_OFS_PUMP_AND_LOOP_POWER_CONTROL[7:0], PDC_OFS_REFERENCE_DIVIDER_LOW[7:0],
        PDC_OFS_REFERENCE_DIVIDER_HIGH[7:0], PDC_OFS_SWALLOW_COUNTER_VALUE[7:0],
        PDC_OFS_FEEDBACK_COUNT_LOW[7:0], PDC_OFS_FEEDBACK_COUNT_HIGH[7:0]};
    localparam logic [7:0] PDC_RST_TABLE [PDC_NUM_REGS] = '{
        PDC_RST_PUMP_AND_LOOP_POWER_CONTROL, PDC_RST_REFERENCE_DIVIDER_LOW,
        PDC_RST_REFERENCE_DIVIDER_HIGH, PDC_RST_SWALLOW_COUNTER_VALUE,
        PDC_RST_FEEDBACK_COUNT_LOW, PDC_RST_FEEDBACK_COUNT_HIGH};
    localparam logic [7:0] PDC_MSK_TABLE [PDC_NUM_REGS] = '{
        PDC_MSK_PUMP_AND_LOOP_POWER_CONTROL, PDC_MSK_REFERENCE_DIVIDER_LOW,
        PDC_MSK_REFERENCE_DIVIDER_HIGH, PDC_MSK_SWALLOW_COUNTER_VALUE,
        PDC_MSK_FEEDBACK_COUNT_LOW, PDC_MSK_FEEDBACK_COUNT_HIGH};

endpackage

`default_nettype wire

/* File: hdl/pdc_byte_reg.sv */
`timescale 1ns/100ps
`default_nettype none

// one configuration byte with a writable-bit mask
module pdc_byte_reg
    import pdc_pkg::*;
#(
    parameter logic [7:0] RESET_VAL  = 8'h00,  // value after reset
    parameter logic [7:0] WRITE_MASK = 8'hFF   // set bits are writable
)(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       wrStrobe,
    input  wire logic [7:0] wrData,
    output var  logic [7:0] q
);

    ////////////////////////////////////////////////////////////////////////////////
    // storage; masked bits never leave zero
    // unused bits dropped
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // reset takes the constant only
            q <= RESET_VAL & WRITE_MASK;
        end
        else if (wrStrobe)
        begin
            // last write wins on usable bits
            q <= wrData & WRITE_MASK;
        end
    end

endmodule // pdc_byte_reg

`default_nettype wire

/* File: hdl/pdc_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none

// configuration byte bank for the loop divider and pump controls
// one request per cycle; every answer comes one cycle later
module pdc_config_regs
    import pdc_pkg::*;
(
    input  wire logic                  sys_clk,          // 250 MHz system clock
    input  wire logic                  rstn,             // async reset, active low
    input  wire logic [PDC_ADDR_W-1:0] regAddr,          // register offset
    input  wire logic                  regWrEn,          // one-cycle write request
    input  wire logic [PDC_DATA_W-1:0] regWrData,        // write byte
    input  wire logic                  regRdEn,          // one-cycle read request
    output var  logic [PDC_DATA_W-1:0] regRdData,        // read byte
    output var  logic                  regRdValid,       // read answer pulse
    output var  logic                  regAddrHit,       // last access was mapped
    output var  logic                  regWrAck,         // write accepted pulse
    output var  logic [1:0]            pumpDriveSelect,  // raw pump drive field
    output var  logic [1:0]            loopPowerSelect,  // raw loop power field
    output var  logic                  pumpTristate,     // pump output high-z
    output var  logic                  pumpForceUp,      // pump sourcing
    output var  logic                  pumpForceDown,    // pump sinking
    output var  logic                  pumpNormal,       // detector-driven pump
    output var  logic                  loopRunning,      // loop normal operation
    output var  logic                  loopAsyncDown,    // async power-down
    output var  logic                  loopSyncDown,     // sync power-down
    output var  logic [PDC_REF_W-1:0]  refDivider,       // reference divide count
    output var  logic [PDC_SWALLOW_W-1:0] swallowCount,  // swallow count
    output var  logic [PDC_FB_W-1:0]   feedbackCount,    // main feedback count
    output var  logic                  refDividerUpdated,// reference byte written
    output var  logic                  feedbackUpdated   // swallow/feedback written
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]              regByte [PDC_NUM_REGS];     // bank contents
    logic [PDC_NUM_REGS-1:0] addrMatch;                  // one-hot slot decode
    logic [PDC_NUM_REGS-1:0] wrHit;                      // per-slot write strobe
    logic                    anyMatch;                   // address lands in bank
    logic [7:0]              next_regRdData;             // read mux result
    logic                    next_pumpTristate;          // decoded pump states
    logic                    next_pumpForceUp;
    logic                    next_pumpForceDown;
    logic                    next_pumpNormal;
    logic                    next_loopRunning;           // decoded loop states
    logic                    next_loopAsyncDown;
    logic                    next_loopSyncDown;
    pdc_pump_t               pumpCode;                   // typed pump field
    pdc_loop_t               loopCode;                   // typed loop field

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and the register slots
    // the upper address bits must be zero; the bank sits in page zero
    // one slot per register, each with its own reset value and mask
    genvar gi;
    generate
        for (gi = 0; gi < PDC_NUM_REGS; gi++)
        begin : g_slot
            // slot match on full offset
            assign addrMatch[gi] = (regAddr == {2'h0, PDC_OFS_LOW_BYTE[gi]});
            // write only on a mapped offset
            assign wrHit[gi] = regWrEn & addrMatch[gi];

            pdc_byte_reg #(
                .RESET_VAL  (PDC_RST_TABLE[gi]),
                .WRITE_MASK (PDC_MSK_TABLE[gi])
            ) u_byte (
                .sys_clk  (sys_clk),
                .rstn     (rstn),
                .wrStrobe (wrHit[gi]),
                .wrData   (regWrData),
                .q        (regByte[gi])
            );
        end
    endgenerate

    // any slot claimed the offset
    assign anyMatch = |addrMatch;

    ////////////////////////////////////////////////////////////////////////////////
    // read multiplexer
    // unmapped offsets read zero so a stray read cannot leak stale data
    always_comb
    begin
        next_regRdData = 8'h00;
        // at most one slot can match an offset
        for (int i = 0; i < PDC_NUM_REGS; i++)
        begin
            if (addrMatch[i])
            begin
                next_regRdData = regByte[i] & PDC_MSK_TABLE[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the request
    // data only changes with a read so it holds for the caller
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // nothing read yet
            regRdData <= 8'h00;
        end
        else if (regRdEn)
        begin
            // masked byte, or zero on a miss
            regRdData <= next_regRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read answer pulse; every read is answered
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // no read in flight
            regRdValid <= 1'b0;
        end
        else
        begin
            // one pulse per request
            regRdValid <= regRdEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write acknowledge pulse
    // a lost write gets no ack, so software can tell
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // no write in flight
            regWrAck <= 1'b0;
        end
        else
        begin
            // ack only writes that landed in the bank
            regWrAck <= regWrEn & anyMatch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mapped flag of the last access
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // no access yet reads as a miss
            regAddrHit <= 1'b0;
        end
        else if (regWrEn | regRdEn)
        begin
            // refreshed on every access, held between them
            regAddrHit <= anyMatch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // raw fields straight from the stored bytes
    // a count is torn here between its two byte writes
    // pump drive field
    assign pumpDriveSelect = regByte[PDC_IDX_CTRL][PDC_PUMP_LSB +: 2];
    assign loopPowerSelect = regByte[PDC_IDX_CTRL][PDC_LOOP_LSB +: 2];
    assign refDivider = {regByte[PDC_IDX_REF_HI][PDC_REF_HI_W-1:0],
                         regByte[PDC_IDX_REF_LO]};
    assign swallowCount = regByte[PDC_IDX_SWALLOW][PDC_SWALLOW_W-1:0];
    assign feedbackCount = {regByte[PDC_IDX_FB_HI][PDC_FB_HI_W-1:0],
                            regByte[PDC_IDX_FB_LO]};

    ////////////////////////////////////////////////////////////////////////////////
    // typed views for decode
    // every two-bit code is a legal member
    assign pumpCode = pdc_pump_t'(pumpDriveSelect);
    assign loopCode = pdc_loop_t'(loopPowerSelect);

    ////////////////////////////////////////////////////////////////////////////////
    // pump mode decode, exactly one flag true
    always_comb
    begin
        next_pumpTristate  = 1'b0;
        next_pumpForceUp   = 1'b0;
        next_pumpForceDown = 1'b0;
        next_pumpNormal    = 1'b0;
        // all four codes are legal, no default
        // pump mode decode
        unique case (pumpCode)
            PDC_PUMP_TRISTATE: next_pumpTristate  = 1'b1;
            PDC_PUMP_FORCE_UP: next_pumpForceUp   = 1'b1;
            PDC_PUMP_FORCE_DN: next_pumpForceDown = 1'b1;
            PDC_PUMP_NORMAL:   next_pumpNormal    = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // loop power decode
    // the reserved code keeps the loop powered down asynchronously:
    // a safe state costs nothing, a running loop on a bad code could lock wrong
    always_comb
    begin
        next_loopRunning   = 1'b0;
        next_loopAsyncDown = 1'b0;
        next_loopSyncDown  = 1'b0;
        // all four codes are decoded, no default
        // loop state decode
        unique case (loopCode)
            PDC_LOOP_NORMAL:   next_loopRunning   = 1'b1;
            PDC_LOOP_ASYNC_PD: next_loopAsyncDown = 1'b1;
            PDC_LOOP_UNUSED:   next_loopAsyncDown = 1'b1;
            PDC_LOOP_SYNC_PD:  next_loopSyncDown  = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered pump flags; one cycle behind the field
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // matches the reset field: normal pump
            pumpTristate  <= 1'b0;
            pumpForceUp   <= 1'b0;
            pumpForceDown <= 1'b0;
            pumpNormal    <= 1'b1;
        end
        else
        begin
            // follow the stored field
            pumpTristate  <= next_pumpTristate;
            pumpForceUp   <= next_pumpForceUp;
            pumpForceDown <= next_pumpForceDown;
            pumpNormal    <= next_pumpNormal;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered loop flags; one cycle behind the field
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // matches the reset field: asynchronous power-down
            loopRunning   <= 1'b0;
            loopAsyncDown <= 1'b1;
            loopSyncDown  <= 1'b0;
        end
        else
        begin
            // follow the stored field
            loopRunning   <= next_loopRunning;
            loopAsyncDown <= next_loopAsyncDown;
            loopSyncDown  <= next_loopSyncDown;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reference update pulse for the divider datapath
    // a multi-byte count is torn between its two writes; the datapath
    // should reload on the pulse that follows the last byte it needs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // no update pending
            refDividerUpdated <= 1'b0;
        end
        else
        begin
            refDividerUpdated <= wrHit[PDC_IDX_REF_LO] | wrHit[PDC_IDX_REF_HI];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // feedback update pulse; the swallow count reloads with it
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            // no update pending
            feedbackUpdated <= 1'b0;
        end
        else
        begin
            feedbackUpdated <= wrHit[PDC_IDX_SWALLOW] | wrHit[PDC_IDX_FB_LO]
                             | wrHit[PDC_IDX_FB_HI];
        end
    end

endmodule // pdc_config_regs

`default_nettype wire

/* File: tb/pdc_config_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// port-level checker for the configuration byte bank
module pdc_config_regs_chk
    import pdc_pkg::*;
(
    input wire logic                     sys_clk,
    input wire logic                     rstn,
    input wire logic [PDC_ADDR_W-1:0]    regAddr,
    input wire logic                     regWrEn,
    input wire logic [PDC_DATA_W-1:0]    regWrData,
    input wire logic                     regRdEn,
    input wire logic [PDC_DATA_W-1:0]    regRdData,
    input wire logic                     regRdValid,
    input wire logic                     regAddrHit,
    input wire logic                     regWrAck,
    input wire logic [1:0]               pumpDriveSelect,
    input wire logic [1:0]               loopPowerSelect,
    input wire logic                     pumpTristate,
    input wire logic                     pumpForceUp,
    input wire logic                     pumpForceDown,
    input wire logic                     pumpNormal,
    input wire logic                     loopRunning,
    input wire logic                     loopAsyncDown,
    input wire logic                     loopSyncDown,
    input wire logic [PDC_REF_W-1:0]     refDivider,
    input wire logic [PDC_SWALLOW_W-1:0] swallowCount,
    input wire logic [PDC_FB_W-1:0]      feedbackCount,
    input wire logic                     refDividerUpdated,
    input wire logic                     feedbackUpdated
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    // offset decode; upper address bits must be zero to match
    logic mapped;  // access lands on one of the six bytes
    assign mapped = (regAddr >= 10'h010) && (regAddr <= 10'h015);

    // write requests per byte and per multi-byte count, used as antecedents below
    sequence ctrlWr;   regWrEn && (regAddr == 10'h010); endsequence
    sequence refLoWr;  regWrEn && (regAddr == 10'h011); endsequence
    sequence refHiWr;  regWrEn && (regAddr == 10'h012); endsequence
    sequence swalWr;   regWrEn && (regAddr == 10'h013); endsequence
    sequence fbLoWr;   regWrEn && (regAddr == 10'h014); endsequence
    sequence fbAnyWr;  regWrEn && (regAddr inside {10'h013, 10'h014, 10'h015}); endsequence
    sequence fbHiWr;   regWrEn && (regAddr == 10'h015); endsequence
    sequence refAnyWr; regWrEn && (regAddr inside {10'h011, 10'h012}); endsequence

    ////////////////////////////////////////////////////////////////////////////////
    ctrl_field_a: assert property (ctrlWr |=>
        {pumpDriveSelect, loopPowerSelect} == ($past(regWrData) & 8'h0F))
        else $error("control fields differ from written byte");
    // decode trails the raw field by one cycle
    pump_decode_a: assert property (1'b1 |=>
        {pumpNormal, pumpForceDown, pumpForceUp, pumpTristate} == (4'h1 << $past(pumpDriveSelect)))
        else $error("pump flags do not match the drive field");
    loop_decode_a: assert property (1'b1 |=>
        loopRunning == ($past(loopPowerSelect) == 2'h0) && loopSyncDown == ($past(loopPowerSelect)
        == 2'h3) && loopAsyncDown == (^$past(loopPowerSelect)))
        else $error("loop flags do not match the power field");
    ref_low_a: assert property (refLoWr |=> refDivider[7:0] == $past(regWrData))
        else $error("reference low byte not stored");
    ref_high_a: assert property (refHiWr |=>
        refDivider[13:8] == ($past(regWrData) & 8'h3F))
        else $error("reference high bits not stored");
    swallow_wr_a: assert property (swalWr |=> swallowCount == ($past(regWrData) & 8'h3F))
        else $error("swallow count not stored");
    fb_high_a: assert property (fbHiWr |=>
        feedbackCount[12:8] == ($past(regWrData) & 8'h1F))
        else $error("feedback high bits not stored");
    ref_hold_a: assert property (!(regWrEn && regAddr inside {10'h011, 10'h012}) |=>
        $stable(refDivider))
        else $error("reference divider changed without a write");
    ref_pulse_a: assert property (refAnyWr |=> refDividerUpdated)
        else $error("reference update pulse missing");
    fb_pulse_a: assert property (fbAnyWr |=> feedbackUpdated)
        else $error("feedback update pulse missing");
    fb_low_a: assert property (fbLoWr |=> feedbackCount[7:0] == $past(regWrData))
        else $error("feedback low byte not stored");
    // unmapped reads answer zero and report a miss
    unmapped_rd_a: assert property (regRdEn && !mapped |=>
        regRdValid && regRdData == 8'h00 && !regAddrHit)
        else $error("unmapped read did not return zero");
    wr_ack_a: assert property (regWrEn && mapped |=> regWrAck && regAddrHit)
        else $error("mapped write not acknowledged");
endmodule // pdc_config_regs_chk

bind pdc_config_regs pdc_config_regs_chk u_chk (.sys_clk, .rstn, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regRdValid, .regAddrHit, .regWrAck, .pumpDriveSelect, .loopPowerSelect,
    .pumpTristate, .pumpForceUp, .pumpForceDown, .pumpNormal, .loopRunning, .loopAsyncDown,
    .loopSyncDown, .refDivider, .swallowCount, .feedbackCount, .refDividerUpdated, .feedbackUpdated);

`default_nettype wire

/* File: tb/pdc_config_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none

// self-checking bench for the configuration byte bank
module pdc_config_regs_tb
    import pdc_pkg::*;
;
    logic        sys_clk, rstn, regWrEn, regRdEn, regRdValid, regAddrHit, regWrAck;
    logic [9:0]  regAddr;
    logic [7:0]  regWrData, regRdData;
    logic [1:0]  pumpDriveSelect, loopPowerSelect;
    logic        pumpTristate, pumpForceUp, pumpForceDown, pumpNormal;
    logic        loopRunning, loopAsyncDown, loopSyncDown, refDividerUpdated, feedbackUpdated;
    logic [13:0] refDivider;
    logic [5:0]  swallowCount;
    logic [12:0] feedbackCount;
    logic [7:0]  shd [6];  // expected register image
    logic [7:0]  rstv [6] = '{8'h0D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00};  // after reset
    logic [7:0]  msk [6] = '{8'h0F, 8'hFF, 8'h3F, 8'h3F, 8'hFF, 8'h1F};   // writable bits
    logic [7:0]  pat [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};                 // write patterns
    int          err_total = 0;
    int          samples_checked = 0;

    pdc_config_regs u_dut (.sys_clk, .rstn, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .regRdValid, .regAddrHit, .regWrAck, .pumpDriveSelect, .loopPowerSelect,
        .pumpTristate, .pumpForceUp, .pumpForceDown, .pumpNormal, .loopRunning, .loopAsyncDown,
        .loopSyncDown, .refDivider, .swallowCount, .feedbackCount, .refDividerUpdated,
        .feedbackUpdated);

    ////////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // compare one value and count it
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one-cycle access from a falling edge; outputs checked one cycle on
    task automatic acc(input logic [9:0] a, input logic w, input logic r, input logic [7:0] d);
        int         k;
        logic [7:0] old;
        k = (a >= 10'h010 && a <= 10'h015) ? int'(a) - 16 : -1;
        old = (k >= 0) ? shd[k] : 8'h00;
        regAddr = a;
        regWrEn = w;
        regRdEn = r;
        regWrData = d;
        // unused bits drop out of the image
        if (w && k >= 0) shd[k] = d & msk[k];
        @(negedge sys_clk);
        chk("regWrAck", regWrAck, w && k >= 0);
        chk("regRdValid", regRdValid, r);
        if (r) chk("regRdData", regRdData, old);
        chk("regAddrHit", regAddrHit, k >= 0);
        chk("refDividerUpdated", refDividerUpdated, w && (k == 1 || k == 2));
        chk("feedbackUpdated", feedbackUpdated, w && k >= 3);
        chk("refDivider", refDivider, {shd[2][5:0], shd[1]});
        chk("swallowCount", swallowCount, shd[3][5:0]);
        chk("feedbackCount", feedbackCount, {shd[5][4:0], shd[4]});
        chk("pumpDriveSelect", pumpDriveSelect, shd[0][3:2]);
        chk("loopPowerSelect", loopPowerSelect, shd[0][1:0]);
    endtask

    // release the strobes and let one edge pass
    task automatic idle();
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        @(negedge sys_clk);
    endtask

    // decoded mode flags against the image
    task automatic flags();
        logic [1:0] l;
        l = shd[0][1:0];
        chk("pumpFlags", {pumpNormal, pumpForceDown, pumpForceUp, pumpTristate},
            4'h1 << shd[0][3:2]);
        chk("loopFlags", {loopSyncDown, loopAsyncDown, loopRunning},
            {l == 2'h3, l == 2'h1 || l == 2'h2, l == 2'h0});
    endtask

    // three-cycle reset, then read every byte back to back
    task automatic reset_and_read();
        rstn = 1'b0;
        repeat (3) @(negedge sys_clk);
        rstn = 1'b1;
        shd = rstv;
        for (int i = 0; i < 6; i++) acc(10'(16 + i), 1'b0, 1'b1, 8'h00);
        idle();
        flags();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        regAddr = 10'h000;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
        reset_and_read();
        // back-to-back writes of every pattern, then readback
        for (int p = 0; p < 4; p++)
        begin
            for (int i = 0; i < 6; i++) acc(10'(16 + i), 1'b1, 1'b0, pat[p]);
            for (int i = 0; i < 6; i++) acc(10'(16 + i), 1'b0, 1'b1, 8'h00);
        end
        idle();
        // every pump and loop code, with the unused nibble set
        for (int c = 0; c < 16; c++)
        begin
            acc(10'h010, 1'b1, 1'b0, {4'hF, 4'(c)});
            idle();
            flags();
        end
        // read and write in one cycle return the old byte
        acc(10'h013, 1'b1, 1'b1, 8'hC7);
        acc(10'h013, 1'b0, 1'b1, 8'h00);
        // neighbours and an alias above 0x0FF must miss
        acc(10'h00F, 1'b1, 1'b1, 8'hFF);
        acc(10'h016, 1'b1, 1'b1, 8'hFF);
        acc(10'h111, 1'b1, 1'b1, 8'hAA);
        acc(10'h011, 1'b0, 1'b1, 8'h00);
        idle();
        // reset in mid-run restores the defaults
        reset_and_read();
        test_done();
    end

    // hang guard: a stuck run is a mismatch
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        test_done();
    end
endmodule // pdc_config_regs_tb

`default_nettype wire
